// file: hdl/tic_pkg.sv
// shared constants, register map and carrier types for the timer interrupt block
package tic_pkg;
    ////////////////////////////////////////////////////////////////////////
    // register byte offsets on the apb bus
    localparam logic [7:0] OFS_EN_SH = 8'h00;
    localparam logic [7:0] OFS_EN_EX = 8'h04;
    localparam logic [7:0] OFS_FL_SH = 8'h08;
    localparam logic [7:0] OFS_FL_EX = 8'h0C;
    localparam logic [7:0] OFS_CAP1_LO = 8'h10;
    localparam logic [7:0] OFS_CAP1_HI = 8'h14;
    localparam logic [7:0] OFS_CAP3_LO = 8'h18;
    localparam logic [7:0] OFS_CAP3_HI = 8'h1C;
    localparam logic [7:0] OFS_CTRL = 8'h20;
    ////////////////////////////////////////////////////////////////////////
    // field positions inside the mask and flag registers
    localparam int BIT_CAP = 5;
    localparam int BIT_CMPA = 4;
    localparam int BIT_CMPB = 3;
    localparam int BIT_OVF = 2;
    localparam int BIT_T3_CMPC = 1;
    localparam int BIT_T1_CMPC = 0;
    // control register fields
    localparam int CTRL_T1_ACOMP = 0;
    localparam int CTRL_LEGACY = 1;
    ////////////////////////////////////////////////////////////////////////
    // implemented bits and reset values
    localparam logic [7:0] MASK_SH = 8'h3C;
    localparam logic [7:0] MASK_EX = 8'h3F;
    localparam logic [7:0] MASK_CTRL = 8'h03;
    localparam logic [7:0] RST_REG = 8'h00;
    localparam logic [15:0] RST_CAP = 16'h0000;
    // waveform modes that use the capture register as top
    localparam logic [3:0] WGM_PC_ICR = 4'h8;
    localparam logic [3:0] WGM_PFC_ICR = 4'hA;
    localparam logic [3:0] WGM_CTC_ICR = 4'hC;
    localparam logic [3:0] WGM_FAST_ICR = 4'hE;
    ////////////////////////////////////////////////////////////////////////
    // per-timer inputs from the counter logic, same clock
    typedef struct packed {
        logic [15:0] counter_value;
        logic [15:0] compare_value_a;
        logic [15:0] compare_value_b;
        logic [15:0] compare_value_c;
        logic [3:0] waveform_mode_select;
        logic tick;
        logic ovf;
        logic top;
    } tic_timer_in_t;
    // compare match set pulses of one timer
    typedef struct packed {
        logic a;
        logic b;
        logic c;
    } tic_match_t;
    // true when the mode takes top from the capture register
    function automatic logic uses_icr_top(input logic [3:0] wgm);
        return (wgm == WGM_PC_ICR) || (wgm == WGM_PFC_ICR) || (wgm == WGM_CTC_ICR) || (wgm == WGM_FAST_ICR);
    endfunction : uses_icr_top
endpackage : tic_pkg

// file: hdl/tic_capture.sv
// capture unit: pin synchroniser, source select, edge detect and counter latch
module tic_capture #(
    parameter int W = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic capture_pin,
    input wire logic comparator_out,
    input wire logic use_comparator,
    input wire logic [W-1:0] counter_value,
    output logic capture_event,
    output logic [W-1:0] capture_value
);
    import tic_pkg::*;
    // only 16-bit counters are served
    if (W != 16) begin : g_bad_width
        $error("tic_capture: only 16-bit counters are served");
    end
    logic [1:0] pin_s1_q, pin_s2_q;
    logic src_prev_q;
    logic [W-1:0] cap_q;
    wire logic src = use_comparator ? pin_s2_q[1] : pin_s2_q[0];
    // rising edge of the selected, synchronised source
    assign capture_event = ce & src & ~src_prev_q;
    assign capture_value = cap_q;
    // two-stage synchronisers, then edge history
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1_q <= 2'h0;
            pin_s2_q <= 2'h0;
            src_prev_q <= 1'b0;
        end else if (ce) begin
            pin_s1_q <= {comparator_out, capture_pin};
            pin_s2_q <= pin_s1_q;
            src_prev_q <= src;
        end
    end
    // latch the running counter on each event
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap_q <= RST_CAP;
        end else if (capture_event) begin
            cap_q <= counter_value;
        end
    end
    property p_capture_latch;
        @(posedge pclk) disable iff (!presetn)
        capture_event |=> capture_value == $past(counter_value);
    endproperty
    a_capture_latch: assert property (p_capture_latch) else $error("capture missed counter value");
endmodule : tic_capture

// file: hdl/tic_match.sv
// compare stage of one timer: match seen on one timer tick, flag set on the next
module tic_match (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input tic_pkg::tic_timer_in_t tin,
    output tic_pkg::tic_match_t set
);
    import tic_pkg::*;
    logic [2:0] hit_q;
    wire logic [2:0] eq = {tin.counter_value == tin.compare_value_a,
        tin.counter_value == tin.compare_value_b, tin.counter_value == tin.compare_value_c};
    // only real matches reach the flags, forced strobes have no path here
    assign set = (ce & tin.tick) ? hit_q : 3'h0;
    // remember the match of the current timer cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hit_q <= 3'h0;
        end else if (ce && tin.tick) begin
            hit_q <= eq;
        end
    end
    sequence s_match_tick;
        ce && tin.tick && tin.counter_value == tin.compare_value_c;
    endsequence
    // the match is held until the next timer tick, which then raises the set pulse
    property p_cmp_next_tick;
        @(posedge pclk) disable iff (!presetn)
        s_match_tick |=> hit_q[0] && (!(ce && tin.tick) || set.c);
    endproperty
    a_cmp_next_tick: assert property (p_cmp_next_tick) else $error("compare flag not set on next tick");
    property p_cmp_only_tick;
        @(posedge pclk) disable iff (!presetn)
        set.a |-> ce && tin.tick && hit_q[2];
    endproperty
    a_cmp_only_tick: assert property (p_cmp_only_tick) else $error("compare flag set without a match");
endmodule : tic_match

// file: hdl/tic_timer_irq.sv
// interrupt masks, flags and capture registers of timers 1 and 3 behind an apb slave
//
// Behaviour
// - each capture event copies the counter into that timer's capture register
// - reading capture low byte parks its high byte in the shared temp byte
// - request needs enable bit, global interrupt flag and event flag together
// - shared mask: t1 capture 5, compare a 4, compare b 3, overflow 2
// - extended mask: t3 bits 5..1, t1 compare c bit 0, bits 7:6 zero
// - shared flags: t1 capture 5, compare a 4, compare b 3, overflow 2
// - extended flags: t3 bits 5..1, t1 compare c bit 0, reset zero
// - capture flag on pin event, or on reaching top when capture is top
// - compare flag set in timer cycle after counter equals compare value
// - forced compare strobe never sets a compare flag
// - overflow flag follows the overflow pulse chosen per waveform mode
// - executing a flag's interrupt vector clears that flag
// - writing one clears a flag, writing zero leaves it
// - legacy mode removes the extended mask register
// - compare c flags behave like the other compare flags
//
// Design decisions made here: the APB slave port and the address map.
module tic_timer_irq (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic global_irq_en,
    input wire logic [7:0] vector_exec_shared,
    input wire logic [7:0] vector_exec_ext,
    input tic_pkg::tic_timer_in_t t1_in,
    input tic_pkg::tic_timer_in_t t3_in,
    input wire logic capture_pin_t1,
    input wire logic capture_pin_t3,
    input wire logic comparator_out,
    output logic [7:0] irq_req_shared,
    output logic [7:0] irq_req_ext
);
    import tic_pkg::*;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    ////////////////////////////////////////////////////////////////////////
    // state
    logic [7:0] en_sh_q, en_ex_q, fl_sh_q, fl_ex_q, ctrl_q, temp_q;
    logic [7:0] irq_sh_q, irq_ex_q;
    logic [31:0] prdata_q;
    logic pready_q, pslverr_q;

    // apply set, vector clear and write-one clear; set wins over both clears
    function automatic logic [7:0] w1c(input logic [7:0] cur, input logic [7:0] set,
        input logic [7:0] clr, input logic [7:0] vec, input logic [7:0] mask);
        return ((cur & ~clr & ~vec) | set) & mask;
    endfunction : w1c

    ////////////////////////////////////////////////////////////////////////
    // capture units and compare stages
    logic cap1_ev, cap3_ev;
    logic [15:0] cap1_val, cap3_val;
    tic_match_t m1, m3;

    tic_capture #(.W(16)) u_cap1 (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .capture_pin(capture_pin_t1),
        .comparator_out(comparator_out),
        .use_comparator(ctrl_q[CTRL_T1_ACOMP]),
        .counter_value(t1_in.counter_value),
        .capture_event(cap1_ev),
        .capture_value(cap1_val)
    );
    // timer 3 has no comparator option
    tic_capture #(.W(16)) u_cap3 (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .capture_pin(capture_pin_t3),
        .comparator_out(1'b0),
        .use_comparator(1'b0),
        .counter_value(t3_in.counter_value),
        .capture_event(cap3_ev),
        .capture_value(cap3_val)
    );
    tic_match u_match1 (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .tin(t1_in),
        .set(m1)
    );
    tic_match u_match3 (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .tin(t3_in),
        .set(m3)
    );

    ////////////////////////////////////////////////////////////////////////
    // apb decode
    wire logic setup = psel & ~penable;
    wire logic done = psel & penable & pready_q & ce;
    wire logic wr_done = done & pwrite;
    wire logic rd_done = done & ~pwrite;
    wire logic legacy = ctrl_q[CTRL_LEGACY];
    wire logic [7:0] wbyte = pwdata[7:0];
    wire logic hit_en_sh = paddr == OFS_EN_SH;
    wire logic hit_en_ex = (paddr == OFS_EN_EX) & ~legacy;
    wire logic hit_fl_sh = paddr == OFS_FL_SH;
    wire logic hit_fl_ex = paddr == OFS_FL_EX;
    wire logic hit_c1_lo = paddr == OFS_CAP1_LO;
    wire logic hit_c1_hi = paddr == OFS_CAP1_HI;
    wire logic hit_c3_lo = paddr == OFS_CAP3_LO;
    wire logic hit_c3_hi = paddr == OFS_CAP3_HI;
    wire logic hit_ctrl = paddr == OFS_CTRL;
    wire logic addr_ok = hit_en_sh | hit_en_ex | hit_fl_sh | hit_fl_ex | hit_c1_lo | hit_c1_hi
        | hit_c3_lo | hit_c3_hi | hit_ctrl;
    // high bytes come from the shared temp byte so the pair reads atomically unless a capture lands in the setup cycle of the low-byte read
    wire logic [7:0] rbyte = hit_en_sh ? en_sh_q :
        hit_en_ex ? en_ex_q :
        hit_fl_sh ? fl_sh_q :
        hit_fl_ex ? fl_ex_q :
        hit_c1_lo ? cap1_val[7:0] :
        hit_c3_lo ? cap3_val[7:0] :
        (hit_c1_hi | hit_c3_hi) ? temp_q :
        hit_ctrl ? ctrl_q : 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // flag set sources
    // capture flag follows top instead of the pin when capture is top
    wire logic cap1_set = uses_icr_top(t1_in.waveform_mode_select) ? (ce & t1_in.top) : cap1_ev;
    wire logic cap3_set = uses_icr_top(t3_in.waveform_mode_select) ? (ce & t3_in.top) : cap3_ev;
    // overflow pulse is already qualified per mode by the counter
    wire logic ovf1_set = ce & t1_in.ovf;
    wire logic ovf3_set = ce & t3_in.ovf;
    wire logic [7:0] set_sh = {2'h0, cap1_set, m1.a, m1.b, ovf1_set, 2'h0};
    wire logic [7:0] set_ex = {2'h0, cap3_set, m3.a, m3.b, ovf3_set, m3.c, m1.c};
    wire logic [7:0] clr_sh = (wr_done & hit_fl_sh) ? wbyte : 8'h00;
    wire logic [7:0] clr_ex = (wr_done & hit_fl_ex) ? wbyte : 8'h00;
    wire logic [7:0] fl_sh_d = w1c(fl_sh_q, set_sh, clr_sh, vector_exec_shared, MASK_SH);
    wire logic [7:0] fl_ex_d = w1c(fl_ex_q, set_ex, clr_ex, vector_exec_ext, MASK_EX);
    // legacy mode hides the extended enables entirely
    wire logic [7:0] en_ex_eff = legacy ? 8'h00 : en_ex_q;
    wire logic [7:0] irq_sh_d = fl_sh_q & en_sh_q & {8{global_irq_en}};
    wire logic [7:0] irq_ex_d = fl_ex_q & en_ex_eff & {8{global_irq_en}};

    ////////////////////////////////////////////////////////////////////////
    // mask and control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_sh_q <= RST_REG;
            en_ex_q <= RST_REG;
            ctrl_q <= RST_REG;
        end else if (wr_done) begin
            if (hit_en_sh) en_sh_q <= wbyte & MASK_SH;
            if (hit_en_ex) en_ex_q <= wbyte & MASK_EX;
            if (hit_ctrl) ctrl_q <= wbyte & MASK_CTRL;
        end
    end

    // flag registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fl_sh_q <= RST_REG;
            fl_ex_q <= RST_REG;
        end else if (ce) begin
            fl_sh_q <= fl_sh_d;
            fl_ex_q <= fl_ex_d;
        end
    end

    // shared temp byte loaded by a low-byte read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            temp_q <= RST_REG;
        end else if (rd_done && (hit_c1_lo || hit_c3_lo)) begin
            temp_q <= hit_c1_lo ? cap1_val[15:8] : cap3_val[15:8];
        end
    end

    // interrupt request levels
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_sh_q <= RST_REG;
            irq_ex_q <= RST_REG;
        end else if (ce) begin
            irq_sh_q <= irq_sh_d;
            irq_ex_q <= irq_ex_d;
        end
    end

    // apb answer: no wait state, data and error prepared in setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else if (ce) begin
            pready_q <= setup;
            pslverr_q <= setup & ~addr_ok;
            if (setup) prdata_q <= {24'h00_0000, rbyte};
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign irq_req_shared = irq_sh_q;
    assign irq_req_ext = irq_ex_q;

    ////////////////////////////////////////////////////////////////////////
    // checks
    property p_temp_pair;
        rd_done && hit_c1_lo |=> temp_q == $past(cap1_val[15:8]);
    endproperty
    a_temp_pair: assert property (p_temp_pair) else $error("temp byte not loaded on low read");

    property p_irq_needs_all;
        ce && !global_irq_en |=> irq_req_shared == 8'h00 && irq_req_ext == 8'h00;
    endproperty
    a_irq_needs_all: assert property (p_irq_needs_all) else $error("request without global enable");

    property p_en_sh_write;
        wr_done && hit_en_sh |=> en_sh_q == ($past(wbyte) & MASK_SH);
    endproperty
    a_en_sh_write: assert property (p_en_sh_write) else $error("shared mask write lost");

    property p_ext_reserved;
        en_ex_q[7:6] == 2'h0 && fl_ex_q[7:6] == 2'h0;
    endproperty
    a_ext_reserved: assert property (p_ext_reserved) else $error("reserved extended bits set");

    property p_flag_set_wins;
        ce |=> (($past(set_ex) & MASK_EX & ~fl_ex_q) == 8'h00) && (($past(set_sh) & MASK_SH & ~fl_sh_q) == 8'h00);
    endproperty
    a_flag_set_wins: assert property (p_flag_set_wins) else $error("flag event lost");

    property p_vector_clear;
        ce |=> ($past(vector_exec_shared & ~set_sh) & fl_sh_q) == 8'h00;
    endproperty
    a_vector_clear: assert property (p_vector_clear) else $error("vector did not clear flag");

    property p_w1c_zero_keeps;
        wr_done && hit_fl_ex |=>
            ((fl_ex_q ^ $past(fl_ex_q)) & ~$past(wbyte | set_ex | vector_exec_ext)) == 8'h00;
    endproperty
    a_w1c_zero_keeps: assert property (p_w1c_zero_keeps) else $error("flag written zero changed");

    property p_legacy_no_ext;
        ce && legacy |=> irq_req_ext == 8'h00;
    endproperty
    a_legacy_no_ext: assert property (p_legacy_no_ext) else $error("extended request in legacy mode");

    sequence s_flag_and_en;
        ce && global_irq_en && fl_sh_q[BIT_OVF] && en_sh_q[BIT_OVF];
    endsequence
    property p_irq_level;
        s_flag_and_en ##1 s_flag_and_en |-> irq_req_shared[BIT_OVF];
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("request dropped while flag held");

    property p_ovf_flag;
        ce && t1_in.ovf |=> fl_sh_q[BIT_OVF];
    endproperty
    a_ovf_flag: assert property (p_ovf_flag) else $error("overflow flag not set");

    property p_cap_top;
        ce && uses_icr_top(t1_in.waveform_mode_select) && !t1_in.top && !fl_sh_q[BIT_CAP] |=> !fl_sh_q[BIT_CAP];
    endproperty
    a_cap_top: assert property (p_cap_top) else $error("capture flag set outside top");
endmodule : tic_timer_irq

// file: dv/tic_core_model.sv
// core-side model: takes interrupt requests and executes their vectors
module tic_core_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ack_en,
    input wire logic [3:0] ack_wait,
    input wire logic [7:0] irq_req_shared,
    input wire logic [7:0] irq_req_ext,
    output logic [7:0] vector_exec_shared,
    output logic [7:0] vector_exec_ext,
    output logic [7:0] n_acks
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] pick;
    ////////////////////////////////////////////////////////////////////////
    // outputs start quiet
    initial begin
        vector_exec_shared = 8'h00;
        vector_exec_ext = 8'h00;
        n_acks = 8'h00;
    end
    // one vector at a time, shared requests first, lowest bit first
    always begin
        @(posedge pclk);
        if (presetn && ack_en && (irq_req_shared | irq_req_ext) != 8'h00) begin
            repeat (ack_wait) @(posedge pclk);
            pick = irq_req_shared & (~irq_req_shared + 8'h01);
            if (pick != 8'h00) begin
                vector_exec_shared <= pick;
            end else begin
                vector_exec_ext <= irq_req_ext & (~irq_req_ext + 8'h01);
            end
            n_acks <= n_acks + 8'h01;
            @(posedge pclk);
            vector_exec_shared <= 8'h00;
            vector_exec_ext <= 8'h00;
            // let the request level fall before looking again
            repeat (3) @(posedge pclk);
        end
    end
endmodule : tic_core_model

// file: dv/tic_timer_irq_tb.sv
// self-checking bench of the timer interrupt mask, flag and capture block
module tic_timer_irq_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import tic_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rdv;
    logic pready, pslverr, err;
    logic gie = 1'b0, cap1 = 1'b0, cap3 = 1'b0, comp = 1'b0, ack_en = 1'b0;
    logic [3:0] ack_wait = 4'h0;
    logic [7:0] vx_sh, vx_ex, irq_sh, irq_ex, n_acks;
    tic_timer_in_t t1_in, t3_in;
    int n_fail = 0;
    int comparisons = 0;
    // free-running bus clock
    always #5 pclk = ~pclk;
    ////////////////////////////////////////////////////////////////////////
    tic_timer_irq u_dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .global_irq_en(gie), .vector_exec_shared(vx_sh), .vector_exec_ext(vx_ex),
        .t1_in(t1_in), .t3_in(t3_in), .capture_pin_t1(cap1), .capture_pin_t3(cap3),
        .comparator_out(comp), .irq_req_shared(irq_sh), .irq_req_ext(irq_ex));
    tic_core_model u_core (.pclk(pclk), .presetn(presetn), .ack_en(ack_en), .ack_wait(ack_wait),
        .irq_req_shared(irq_sh), .irq_req_ext(irq_ex), .vector_exec_shared(vx_sh),
        .vector_exec_ext(vx_ex), .n_acks(n_acks));
    ////////////////////////////////////////////////////////////////////////
    task automatic tk(input int n);
        repeat (n) @(posedge pclk);
    endtask : tk
    task automatic close_out;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : close_out
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // one apb transfer, entered just after a rising edge; idles one cycle after
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rdv = prdata;
        err = pslverr;
        if (pready !== 1'b1) begin
            n_fail++;
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        xfer(1'b1, a, d);
    endtask : wr
    // read a register and judge both data and error answer
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic ee = 1'b0);
        xfer(1'b0, a, 8'h00);
        check($sformatf("data %h", a), rdv, {24'h00_0000, e});
        check($sformatf("err %h", a), {31'h0000_0000, err}, {31'h0000_0000, ee});
    endtask : rd
    // one timer clock on both timers
    task automatic pulse_tick;
        t1_in.tick <= 1'b1;
        t3_in.tick <= 1'b1;
        tk(1);
        t1_in.tick <= 1'b0;
        t3_in.tick <= 1'b0;
        tk(1);
    endtask : pulse_tick
    ////////////////////////////////////////////////////////////////////////
    // reset values, access kinds, unmapped address
    task automatic t_regs;
        for (int i = 0; i < 9; i++) begin
            rd(8'(i * 4), 8'h00);
        end
        rd(8'h24, 8'h00, 1'b1);
        wr(OFS_EN_SH, 8'hFF);
        rd(OFS_EN_SH, 8'h3C);
        wr(OFS_EN_EX, 8'h3F);
        rd(OFS_EN_EX, 8'h3F);
        wr(OFS_FL_EX, 8'h3F);
        rd(OFS_FL_EX, 8'h00);
        wr(OFS_EN_SH, 8'h00);
        wr(OFS_EN_EX, 8'h00);
    endtask : t_regs
    // overflow flags, request gating and level, write-one clear
    task automatic t_ovf;
        wr(OFS_EN_SH, 8'h04);
        gie <= 1'b1;
        t1_in.ovf <= 1'b1;
        t3_in.ovf <= 1'b1;
        tk(1);
        t1_in.ovf <= 1'b0;
        t3_in.ovf <= 1'b0;
        tk(3);
        check("irq sh", irq_sh, 8'h04);
        check("irq ex", irq_ex, 8'h00);
        tk(20);
        check("irq hold", irq_sh, 8'h04);
        gie <= 1'b0;
        tk(3);
        check("irq gie", irq_sh, 8'h00);
        rd(OFS_FL_SH, 8'h04);
        rd(OFS_FL_EX, 8'h04);
        wr(OFS_FL_SH, 8'h00);
        rd(OFS_FL_SH, 8'h04);
        wr(OFS_FL_SH, 8'h04);
        wr(OFS_FL_EX, 8'h04);
        rd(OFS_FL_SH, 8'h00);
        rd(OFS_FL_EX, 8'h00);
        wr(OFS_EN_SH, 8'h00);
    endtask : t_ovf
    // every compare channel: no flag on the matching tick, flag on the next
    task automatic t_cmp;
        logic [7:0] fa [6] = '{OFS_FL_SH, OFS_FL_SH, OFS_FL_EX, OFS_FL_EX, OFS_FL_EX, OFS_FL_EX};
        logic [7:0] fb [6] = '{8'h10, 8'h08, 8'h01, 8'h10, 8'h08, 8'h02};
        logic [15:0] cv;
        for (int i = 0; i < 6; i++) begin
            cv = 16'(16'h1111 * (i % 3 + 1));
            if (i < 3) begin
                t1_in.counter_value <= cv;
            end else begin
                t3_in.counter_value <= cv;
            end
            pulse_tick;
            t1_in.counter_value <= 16'h0000;
            t3_in.counter_value <= 16'h0000;
            tk(2);
            rd(fa[i], 8'h00);
            pulse_tick;
            tk(2);
            rd(fa[i], fb[i]);
            wr(fa[i], fb[i]);
            rd(fa[i], 8'h00);
        end
    endtask : t_cmp
    // pin and comparator capture, shared temp byte, capture as top
    task automatic t_cap;
        t1_in.counter_value <= 16'hABCD;
        t3_in.counter_value <= 16'h5678;
        cap1 <= 1'b1;
        cap3 <= 1'b1;
        tk(6);
        rd(OFS_FL_SH, 8'h20);
        rd(OFS_FL_EX, 8'h20);
        rd(OFS_CAP3_LO, 8'h78);
        rd(OFS_CAP1_LO, 8'hCD);
        rd(OFS_CAP3_HI, 8'hAB);
        rd(OFS_CAP3_LO, 8'h78);
        rd(OFS_CAP3_HI, 8'h56);
        cap1 <= 1'b0;
        cap3 <= 1'b0;
        wr(OFS_FL_EX, 8'h20);
        wr(OFS_CTRL, 8'h01);
        t1_in.counter_value <= 16'h1234;
        comp <= 1'b1;
        tk(6);
        rd(OFS_CAP1_LO, 8'h34);
        rd(OFS_CAP1_HI, 8'h12);
        wr(OFS_CTRL, 8'h00);
        comp <= 1'b0;
        t1_in.waveform_mode_select <= WGM_CTC_ICR;
        wr(OFS_FL_SH, 8'h20);
        cap1 <= 1'b1;
        tk(6);
        rd(OFS_FL_SH, 8'h00);
        t1_in.top <= 1'b1;
        tk(1);
        t1_in.top <= 1'b0;
        tk(3);
        rd(OFS_FL_SH, 8'h20);
        wr(OFS_FL_SH, 8'h20);
        cap1 <= 1'b0;
        t1_in.waveform_mode_select <= 4'h0;
        t1_in.counter_value <= 16'h0000;
        t3_in.counter_value <= 16'h0000;
    endtask : t_cap
    // vectors executed by the core clear their flags, prompt and slow
    task automatic t_vec;
        ack_en <= 1'b1;
        gie <= 1'b1;
        wr(OFS_EN_SH, 8'h04);
        wr(OFS_EN_EX, 8'h10);
        for (int i = 0; i < 2; i++) begin
            ack_wait <= 4'(i * 15);
            t1_in.ovf <= 1'b1;
            t3_in.counter_value <= 16'h1111;
            pulse_tick;
            t1_in.ovf <= 1'b0;
            t3_in.counter_value <= 16'h0000;
            pulse_tick;
            tk(60);
            check("acks", n_acks, 8'(2 * i + 2));
            rd(OFS_FL_SH, 8'h00);
            rd(OFS_FL_EX, 8'h00);
        end
        ack_en <= 1'b0;
        wr(OFS_EN_SH, 8'h00);
    endtask : t_vec
    // legacy mode hides the extended mask and its requests
    task automatic t_legacy;
        wr(OFS_CTRL, 8'h02);
        rd(OFS_EN_EX, 8'h00, 1'b1);
        wr(OFS_EN_EX, 8'h3F);
        t3_in.counter_value <= 16'h1111;
        pulse_tick;
        t3_in.counter_value <= 16'h0000;
        pulse_tick;
        tk(3);
        check("irq legacy", irq_ex, 8'h00);
        rd(OFS_FL_EX, 8'h10);
        wr(OFS_CTRL, 8'h00);
        rd(OFS_EN_EX, 8'h10);
        check("irq back", irq_ex, 8'h10);
        wr(OFS_FL_EX, 8'h10);
    endtask : t_legacy
    ////////////////////////////////////////////////////////////////////////
    // reset, then the scenarios in turn
    initial begin
        t1_in = {16'h0000, 16'h1111, 16'h2222, 16'h3333, 4'h0, 3'b000};
        t3_in = {16'h0000, 16'h1111, 16'h2222, 16'h3333, 4'h0, 3'b000};
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_ovf;
        t_cmp;
        t_cap;
        t_vec;
        t_legacy;
        close_out;
    end
    // watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge pclk);
        n_fail++;
        close_out;
    end
endmodule : tic_timer_irq_tb
